// ### rtl/compact_timer_pkg.sv
// Package for the compact timer: register map, field layout, reset values and types
package compact_timer_pkg;

	// Word offsets on the Avalon-MM bus (byte address = 4 * index)
	localparam logic [2:0] REG_CTRL0     = 3'h0;
	localparam logic [2:0] REG_CTRL1     = 3'h1;
	localparam logic [2:0] REG_COUNT_LO  = 3'h2;
	localparam logic [2:0] REG_COUNT_HI  = 3'h3;
	localparam logic [2:0] REG_CMPA_LO   = 3'h4;
	localparam logic [2:0] REG_CMPA_HI   = 3'h5;
	localparam logic [2:0] REG_FLAGS     = 3'h6;

	// Control 0 fields
	localparam int CTRL0_PAUSE_BIT  = 7;
	localparam int CTRL0_ENABLE_BIT = 3;
	// Control 1 fields
	localparam int CTRL1_MODE_HI    = 7;
	localparam int CTRL1_PIN_HI     = 5;
	localparam int CTRL1_OC_BIT     = 3;
	localparam int CTRL1_POL_BIT    = 2;
	localparam int CTRL1_SWAP_BIT   = 1;
	localparam int CTRL1_CLR_BIT    = 0;
	// Flag register fields (write one to clear)
	localparam int FLAG_A_BIT       = 0;
	localparam int FLAG_P_BIT       = 1;

	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [9:0] CMPA_RESET   = 10'h000;
	localparam logic [9:0] COUNT_MAX    = 10'h3ff;
	localparam logic [2:0] FIELD_DIV4   = 3'h0;
	localparam logic [1:0] DIV4_LAST    = 2'h3;

	typedef enum logic [1:0] {
		MODE_COMPARE = 2'h0,
		MODE_UNDEF   = 2'h1,
		MODE_PWM     = 2'h2,
		MODE_TIMER   = 2'h3
	} mode_t;

	// Decoded control bits, carried together
	typedef struct packed {
		logic       pause;
		logic [2:0] clk_sel;
		logic       enable;
		logic [2:0] period_code;
		mode_t      mode;
		logic [1:0] pin_function;
		logic       output_control;
		logic       output_polarity;
		logic       period_duty_swap;
		logic       clear_select;
	} ctrl_t;

	// Avalon-MM slave request
	typedef struct packed {
		logic [2:0] address;
		logic       read;
		logic       write;
		logic [7:0] writedata;
	} bus_req_t;

endpackage : compact_timer_pkg

// ### rtl/compact_timer.sv
// Compact 10-bit timer with compare-match, timer/counter and PWM modes
//
// Behaviour
// [RQ1] Comparator A value is 10 bits: low byte register plus two bits high.
// [RQ2] Mode field: 00 compare-match, 11 timer/counter, 10 PWM.
// [RQ3] Clear-select low: clear on P match or overflow; raise A and P flags.
// [RQ4] Clear-select high: clear on A match; raise only the A flag.
// [RQ5] Clear-select high, A value zero: overflow at 3FF, no A flag.
// [RQ6] Compare-match mode: only A matches change the pin.
// [RQ7] A match sets, clears or toggles pin per pin function; zero means none.
// [RQ8] Enable rising edge loads pin with output-control initial level.
// [RQ9] Timer/counter mode counts like compare-match mode but leaves pin unused.
// [RQ10] PWM mode ignores the clear-select bit.
// [RQ11] PWM, swap low: period from code (000 is 1024), duty from A.
// [RQ12] Duty at or above period gives 100 percent duty.
// [RQ13] PWM, swap high: period from A, duty from code times 128.
// [RQ14] PWM mode raises A and P flags on each comparator match.
// [RQ15] PWM keeps running when pin function forces inactive or active level.
// [RQ16] Output-control picks active level; polarity inverts final pin.
// [RQ17] Each period-comparator counter clear starts a new PWM period.
// [RQ18] Enable rising clears counter; falling enable holds the count.
// [RQ19] Period code compares only with counter bits 9 to 7.
// [RQ20] Pin updates on the same timer tick as the flag and clear; timer_out here changes one clock after the flag.
`timescale 1ns/1ns
`default_nettype none

module compact_timer
	import compact_timer_pkg::*;
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// Avalon-MM slave
	input  wire logic [2:0]       avs_address,
	input  wire logic             avs_read,
	input  wire logic             avs_write,
	input  wire logic [7:0]       avs_writedata,
	output logic      [7:0]       avs_readdata,
	output logic                  avs_waitrequest,
	// Timer clock sources and pin
	input  wire logic             fast_tick,
	input  wire logic             slow_tick,
	input  wire logic             ext_clk_in,
	output logic                  timer_out,
	output logic                  timer_out_en,
	output logic                  match_a_flag,
	output logic                  match_p_flag
);
	import compact_timer_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Registers

	logic [7:0] ctrl0_q;
	logic [7:0] ctrl1_q;
	logic [9:0] compare_a_value_q;
	logic [9:0] count_q;
	logic       flag_a_q;
	logic       flag_p_q;
	logic       pin_q;
	logic       pwm_q;
	logic       enable_prev_q;
	logic       ext_prev_q;
	logic [1:0] div_q;
	logic       ack_q;
	logic [7:0] rdata_q;
	ctrl_t      ctrl;
	bus_req_t   req;

	assign req = '{address: avs_address, read: avs_read, write: avs_write,
		writedata: avs_writedata};

	assign ctrl.pause            = ctrl0_q[CTRL0_PAUSE_BIT];
	assign ctrl.clk_sel          = ctrl0_q[6:4];
	assign ctrl.enable           = ctrl0_q[CTRL0_ENABLE_BIT];
	assign ctrl.period_code      = ctrl0_q[2:0];
	// [RQ2] mode decode
	assign ctrl.mode             = mode_t'(ctrl1_q[CTRL1_MODE_HI -: 2]);
	assign ctrl.pin_function     = ctrl1_q[CTRL1_PIN_HI -: 2];
	assign ctrl.output_control   = ctrl1_q[CTRL1_OC_BIT];
	assign ctrl.output_polarity  = ctrl1_q[CTRL1_POL_BIT];
	assign ctrl.period_duty_swap = ctrl1_q[CTRL1_SWAP_BIT];
	assign ctrl.clear_select     = ctrl1_q[CTRL1_CLR_BIT];

	////////////////////////////////////////////////////////////////////////////
	// Timer clock selection: one-cycle tick pulses only

	wire ext_rise = ext_clk_in & ~ext_prev_q;
	wire ext_fall = ~ext_clk_in & ext_prev_q;
	wire div4_tick = (div_q == DIV4_LAST);
	logic sel_tick;

	always_comb
	begin
		unique case (ctrl.clk_sel)
			3'h0: sel_tick = div4_tick;
			3'h1: sel_tick = 1'b1;
			3'h2: sel_tick = fast_tick;
			3'h3: sel_tick = fast_tick & div4_tick;
			3'h4: sel_tick = slow_tick;
			3'h5: sel_tick = slow_tick;
			3'h6: sel_tick = ext_rise;
			3'h7: sel_tick = ext_fall;
		endcase
	end

	wire enable_rise = ctrl.enable & ~enable_prev_q;
	wire tick = sel_tick & ctrl.enable & ~ctrl.pause & ~enable_rise;

	////////////////////////////////////////////////////////////////////////////
	// Comparators and clear decision

	wire is_pwm = (ctrl.mode == MODE_PWM);
	// Match on the coming count so a clear gives a span of exactly the compare value
	wire [9:0] count_inc = count_q + 10'h001;
	// [RQ19] period code sees only counter bits 9..7
	wire match_p = (ctrl.period_code != 3'h0) && (count_inc[9:7] == ctrl.period_code);
	wire match_a = (compare_a_value_q != 10'h000) && (count_inc == compare_a_value_q);
	wire at_top  = (count_q == COUNT_MAX);
	// [RQ11] code 000 means a full 1024-clock span
	wire span_end = (ctrl.period_code == 3'h0) ? at_top : match_p;

	logic clear_cnt;
	logic set_a;
	logic set_p;

	always_comb
	begin
		if (is_pwm)
		begin
			// [RQ10] clear-select ignored; [RQ17] period comparator restarts
			clear_cnt = ctrl.period_duty_swap ? (match_a | at_top) : (span_end | at_top);
			// [RQ14] both flags in PWM mode
			set_a = match_a;
			set_p = match_p;
		end
		else if (ctrl.clear_select)
		begin
			// [RQ4] clear on A, A flag only; [RQ5] zero A overflows silently
			clear_cnt = match_a | at_top;
			set_a = match_a;
			set_p = 1'b0;
		end
		else
		begin
			// [RQ3] clear on P or overflow, both flags; [RQ9] same for timer mode
			clear_cnt = span_end | at_top;
			set_a = match_a;
			set_p = match_p;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// PWM waveform: active while count is below duty

	wire [10:0] duty_val   = ctrl.period_duty_swap ? {1'b0, compare_a_value_q}
		: {1'b0, compare_a_value_q};
	wire [10:0] code_val   = (ctrl.period_code == 3'h0) ? 11'h400
		: {1'b0, ctrl.period_code, 7'h00};
	wire [10:0] duty_eff   = ctrl.period_duty_swap ? code_val : duty_val;
	// [RQ13] swap high: period from A, duty from code
	wire [10:0] period_eff = ctrl.period_duty_swap ? {1'b0, compare_a_value_q} : code_val;
	// [RQ12] duty at or above period holds active
	wire [10:0] count_next = clear_cnt ? 11'h000 : {1'b0, count_q} + 11'h001;
	wire pwm_active = (duty_eff >= period_eff) || (count_next < duty_eff);

	////////////////////////////////////////////////////////////////////////////
	// Pin function in compare mode

	logic pin_next;

	always_comb
	begin
		// [RQ6] [RQ7] only a flagged A match drives the pin
		unique case (ctrl.pin_function)
			2'h0: pin_next = pin_q;
			2'h1: pin_next = 1'b0;
			2'h2: pin_next = 1'b1;
			2'h3: pin_next = ~pin_q;
		endcase
	end

	// [RQ16] active level from output-control, then polarity inversion
	wire pwm_level = (pwm_active ~^ ctrl.output_control);
	logic pin_drive;

	always_comb
	begin
		if (is_pwm)
		begin
			// [RQ15] forced levels leave the waveform running
			unique case (ctrl.pin_function)
				2'h0: pin_drive = ~ctrl.output_control;
				2'h1: pin_drive = ctrl.output_control;
				default: pin_drive = pwm_q;
			endcase
		end
		else
			pin_drive = pin_q;
	end

	////////////////////////////////////////////////////////////////////////////
	// Counter, divider, pin state

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			count_q       <= 10'h000;
			pin_q         <= 1'b0;
			pwm_q         <= 1'b0;
			enable_prev_q <= 1'b0;
			ext_prev_q    <= 1'b0;
			div_q         <= 2'h0;
		end
		else
		begin
			enable_prev_q <= ctrl.enable;
			ext_prev_q    <= ext_clk_in;
			div_q         <= div_q + 2'h1;
			// [RQ18] restart from zero; falling enable just stops ticks
			if (enable_rise)
			begin
				count_q <= 10'h000;
				// [RQ8] initial level
				pin_q   <= ctrl.output_control;
				pwm_q   <= ctrl.output_control;
			end
			else if (tick)
			begin
				count_q <= count_next[9:0];
				// [RQ20] pin changes on the matching tick
				if (set_a && ctrl.mode == MODE_COMPARE)
					pin_q <= pin_next;
				pwm_q <= pwm_level;
			end
		end
	end

	// Output enable low in timer/counter mode frees the pin
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			timer_out    <= 1'b0;
			timer_out_en <= 1'b0;
		end
		else
		begin
			// [RQ9] pin unused in timer mode
			timer_out_en <= ctrl.enable & (ctrl.mode != MODE_TIMER);
			timer_out    <= pin_drive ^ ctrl.output_polarity;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register bus: one wait cycle, readback of control, count and flags

	wire access = req.read | req.write;
	wire take   = access & ack_q;
	wire clr_a  = take & req.write & (req.address == REG_FLAGS)
		& req.writedata[FLAG_A_BIT];
	wire clr_p  = take & req.write & (req.address == REG_FLAGS)
		& req.writedata[FLAG_P_BIT];
	wire hit_a  = tick & set_a;
	wire hit_p  = tick & set_p;

	logic [7:0] rd_mux;

	always_comb
	begin
		unique case (req.address)
			REG_CTRL0:    rd_mux = ctrl0_q;
			REG_CTRL1:    rd_mux = ctrl1_q;
			REG_COUNT_LO: rd_mux = count_q[7:0];
			REG_COUNT_HI: rd_mux = {6'h00, count_q[9:8]};
			// [RQ1] comparator A halves, upper six bits read zero
			REG_CMPA_LO:  rd_mux = compare_a_value_q[7:0];
			REG_CMPA_HI:  rd_mux = {6'h00, compare_a_value_q[9:8]};
			REG_FLAGS:    rd_mux = {6'h00, flag_p_q, flag_a_q};
			default:      rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			ctrl0_q           <= CTRL_RESET;
			ctrl1_q           <= CTRL_RESET;
			compare_a_value_q <= CMPA_RESET;
			flag_a_q          <= 1'b0;
			flag_p_q          <= 1'b0;
			ack_q             <= 1'b0;
			rdata_q           <= 8'h00;
		end
		else
		begin
			ack_q <= access & ~ack_q;
			if (access & ~ack_q)
				rdata_q <= rd_mux;
			if (take & req.write)
			begin
				unique case (req.address)
					REG_CTRL0:   ctrl0_q <= req.writedata;
					REG_CTRL1:   ctrl1_q <= req.writedata;
					// [RQ1] 10-bit comparator A value
					REG_CMPA_LO: compare_a_value_q[7:0] <= req.writedata;
					REG_CMPA_HI: compare_a_value_q[9:8] <= req.writedata[1:0];
					default:     ;
				endcase
			end
			// Set wins over a clear in the same cycle
			flag_a_q <= hit_a | (flag_a_q & ~clr_a);
			flag_p_q <= hit_p | (flag_p_q & ~clr_p);
		end
	end

	assign avs_readdata    = rdata_q;
	assign avs_waitrequest = ~ack_q;
	assign match_a_flag    = flag_a_q;
	assign match_p_flag    = flag_p_q;

endmodule : compact_timer

`default_nettype wire

// ### tb/compact_timer_props.sv
// Concurrent checks on the compact timer ports
`timescale 1ns/1ns
`default_nettype none
module compact_timer_props
	import compact_timer_pkg::*;
(
	// Clock, reset and bus
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic [2:0] avs_address,
	input wire logic       avs_read,
	input wire logic       avs_write,
	input wire logic [7:0] avs_writedata,
	input wire logic [7:0] avs_readdata,
	input wire logic       avs_waitrequest,
	// Pin and flags
	input wire logic       timer_out,
	input wire logic       timer_out_en,
	input wire logic       match_a_flag,
	input wire logic       match_p_flag
);
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
// Shadow control words; checks wait until a write has settled
logic [7:0] c0_q;
logic [7:0] c1_q;
logic [9:0] ca_q;
logic [2:0] age_q;
wire acc = avs_write && !avs_waitrequest;
wire settled = age_q == 3'h7;
wire en_rise = acc && avs_address == REG_CTRL0 && avs_writedata[3] && !c0_q[3];
wire cmp_like = c1_q[7:6] != MODE_PWM;
always_ff @(posedge clk)
begin
	if (!resetn)
	begin
		age_q <= 3'h0;
		c0_q  <= CTRL_RESET;
		c1_q  <= CTRL_RESET;
	end
	else
	begin
		age_q <= acc ? 3'h0 : (settled ? age_q : age_q + 3'h1);
		if (acc && avs_address == REG_CTRL0) c0_q <= avs_writedata;
		if (acc && avs_address == REG_CTRL1) c1_q <= avs_writedata;
	end
end
always_ff @(posedge clk)
begin
	if (!resetn)
		ca_q <= CMPA_RESET;
	else if (acc && avs_address == REG_CMPA_LO)
		ca_q[7:0] <= avs_writedata;
	else if (acc && avs_address == REG_CMPA_HI)
		ca_q[9:8] <= avs_writedata[1:0];
end
////////////////////////////////////////
a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
	else $error("waitrequest held too long");
a_read_hi: assert property (avs_read && !avs_waitrequest && avs_address == REG_CMPA_HI
	|-> avs_readdata[7:2] == 6'h0) else $error("compare high bits not zero");
a_en_timer: assert property (settled |-> timer_out_en == (c0_q[3] && c1_q[7:6] != MODE_TIMER))
	else $error("pin enable wrong for mode");
a_no_p_flag: assert property (settled && cmp_like && c1_q[0] && !match_p_flag |=> !match_p_flag)
	else $error("P flag raised with clear on A");
a_no_a_zero: assert property (settled && cmp_like && c1_q[0] && ca_q == 10'h0 && !match_a_flag
	|=> !match_a_flag) else $error("A flag raised with zero compare");
a_pin_by_a: assert property (settled && c1_q[7:6] == MODE_COMPARE && $changed(timer_out)
	|-> match_a_flag) else $error("pin moved without A match");
a_pwm_force: assert property (settled && c0_q[3] && c1_q[7:6] == MODE_PWM && !c1_q[5]
	|-> timer_out == ((c1_q[4] == c1_q[3]) ^ c1_q[2])) else $error("forced PWM level wrong");
a_init_level: assert property (en_rise && c1_q[7:6] == MODE_COMPARE && !c1_q[2]
	|-> ##[1:3] timer_out == c1_q[3]) else $error("pin not at initial level");
c_pwm_run: cover property (settled && c0_q[3] && c1_q[7:6] == MODE_PWM && timer_out);
c_p_rise: cover property ($rose(match_p_flag));
c_a_rise: cover property ($rose(match_a_flag));
endmodule : compact_timer_props
bind compact_timer compact_timer_props chk_u (.clk, .resetn, .avs_address, .avs_read,
	.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .timer_out,
	.timer_out_en, .match_a_flag, .match_p_flag);
`default_nettype wire

// ### tb/load_meter.sv
// External load on the timer pin: counts cycles it sees the pin high
`timescale 1ns/1ns
`default_nettype none
module load_meter
(
	// Clock and measurement control
	input  wire logic        clk,
	input  wire logic        clr,
	input  wire logic        gate,
	// Pin as seen by the load
	input  wire logic        pin,
	input  wire logic        pin_en,
	output logic      [15:0] high_cnt
);
// A released pin reads low through the load's pull-down
wire level = pin_en ? pin : 1'b0;
always_ff @(posedge clk)
begin
	if (clr)
		high_cnt <= 16'h0;
	else if (gate)
		high_cnt <= high_cnt + {15'h0, level};
end
endmodule : load_meter
`default_nettype wire

// ### tb/test_compact_timer.sv
// Self-checking bench for the compact timer
`timescale 1ns/1ns
`default_nettype none
module test_compact_timer;
import compact_timer_pkg::*;
logic        clk, resetn, avs_read, avs_write, avs_waitrequest, gate, clr;
logic        timer_out, timer_out_en, match_a_flag, match_p_flag;
logic [2:0]  avs_address;
logic [7:0]  avs_writedata, avs_readdata, rdata;
logic [15:0] high_cnt;
int          error_cnt, n_checks;
compact_timer dut_u (.clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
	.avs_readdata, .avs_waitrequest, .fast_tick(1'b0), .slow_tick(1'b0), .ext_clk_in(1'b0),
	.timer_out, .timer_out_en, .match_a_flag, .match_p_flag);
load_meter load_u (.clk, .clr, .gate, .pin(timer_out), .pin_en(timer_out_en), .high_cnt);
initial
begin
	clk = 1'b0;
	forever #50 clk = ~clk;
end
initial
begin
	#5000000;
	error_cnt++;
	summarize();
end
////////////////////////////////////////
task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
	n_checks++;
	if (seen !== exp)
	begin
		error_cnt++;
		$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
	end
endtask : chk
// Holds the request until waitrequest is sampled low
task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
	int n;
	@(posedge clk);
	avs_address   <= a;
	avs_writedata <= d;
	avs_write     <= wr;
	avs_read      <= !wr;
	for (n = 0; n < 20; n++)
	begin
		@(posedge clk);
		if (avs_waitrequest === 1'b0) break;
	end
	if (n == 20) error_cnt++;
	rdata = avs_readdata;
	avs_write <= 1'b0;
	avs_read  <= 1'b0;
endtask : bus
task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
	bus(1'b0, a, 8'h00);
	chk({8'h00, rdata}, {8'h00, e});
endtask : rdchk
// Mode bits change only while the counter is off
task automatic start(input logic [7:0] c1, input logic [2:0] code, input logic [9:0] ca);
	bus(1'b1, REG_CTRL0, {5'h02, code});
	bus(1'b1, REG_CTRL1, c1);
	bus(1'b1, REG_CMPA_LO, ca[7:0]);
	bus(1'b1, REG_CMPA_HI, {6'h00, ca[9:8]});
	bus(1'b1, REG_FLAGS, 8'h03);
	bus(1'b1, REG_CTRL0, {5'h03, code});
endtask : start
task automatic regs_case;
	rdchk(REG_CMPA_HI, 8'h00);
	bus(1'b1, REG_CMPA_LO, 8'hff);
	bus(1'b1, REG_CMPA_HI, 8'hff);
	rdchk(REG_CMPA_LO, 8'hff);
	rdchk(REG_CMPA_HI, 8'h03);
	bus(1'b1, 3'h7, 8'h5a);
	rdchk(3'h7, 8'h00);
endtask : regs_case
task automatic compare_case;
	logic [3:0] exp_pin;
	exp_pin = 4'b1100;
	for (int f = 0; f < 4; f++)
	begin
		start({2'b00, f[1:0], 4'h0}, 3'h2, 10'd64);
		repeat (100) @(posedge clk);
		chk({15'h0, timer_out}, {15'h0, exp_pin[f]});
		repeat (200) @(posedge clk);
		rdchk(REG_COUNT_HI, 8'h00);
		chk({14'h0, match_p_flag, match_a_flag}, 16'h3);
	end
	start(8'hc0, 3'h1, 10'd64);
	repeat (300) @(posedge clk);
	chk({14'h0, timer_out_en, match_a_flag}, 16'h1);
endtask : compare_case
task automatic clear_case;
	start(8'h01, 3'h1, 10'd300);
	repeat (700) @(posedge clk);
	chk({14'h0, match_p_flag, match_a_flag}, 16'h1);
	start(8'h09, 3'h1, 10'd0);
	repeat (1100) @(posedge clk);
	chk({13'h0, timer_out, match_p_flag, match_a_flag}, 16'h4);
endtask : clear_case
// Counts high cycles over a whole number of periods
task automatic pwm_case(input logic [7:0] c1, input logic [2:0] code, input logic [9:0] ca,
	input logic [15:0] e, input logic ea);
	start(c1, code, ca);
	repeat (16) @(posedge clk);
	clr <= 1'b1;
	@(posedge clk);
	clr  <= 1'b0;
	gate <= 1'b1;
	repeat (2048) @(posedge clk);
	gate <= 1'b0;
	@(posedge clk);
	chk(high_cnt, e);
	chk({15'h0, match_a_flag}, {15'h0, ea});
endtask : pwm_case
task automatic summarize;
	if (error_cnt == 0 && n_checks > 0)
		$display("Regression OK");
	else
		$display("Regression broken");
	$finish;
endtask : summarize
initial
begin
	{resetn, avs_read, avs_write, gate, clr} = 5'h0;
	avs_address   = 3'h0;
	avs_writedata = 8'h00;
	error_cnt     = 0;
	n_checks      = 0;
	repeat (10) @(posedge clk);
	resetn <= 1'b1;
	regs_case();
	compare_case();
	clear_case();
	pwm_case(8'ha9, 3'h1, 10'd32, 16'd512, 1'b1);
	pwm_case(8'ha8, 3'h1, 10'd200, 16'd2048, 1'b0);
	pwm_case(8'hac, 3'h1, 10'd32, 16'd1536, 1'b1);
	pwm_case(8'ha0, 3'h1, 10'd32, 16'd1536, 1'b1);
	pwm_case(8'haa, 3'h1, 10'd256, 16'd1024, 1'b1);
	pwm_case(8'h88, 3'h1, 10'd32, 16'd0, 1'b1);
	pwm_case(8'h98, 3'h1, 10'd32, 16'd2048, 1'b1);
	pwm_case(8'ha8, 3'h0, 10'd256, 16'd512, 1'b1);
	summarize();
end
endmodule : test_compact_timer
`default_nettype wire
